// *** core/fbx_pkg.sv ***
// Purpose: Shared constants and types of the flag branch and bit op unit
// Assumes: 8-bit data, one-word instructions, 16-bit program counter
// Notes: Op codes are the decoded form handed in by the fetch stage
package fbx_pkg;

   localparam int PC_W = 16;
   localparam int DATA_W = 8;
   localparam int IO_ADDR_W = 5;
   localparam int REG_SEL_W = 5;
   localparam int BUS_ADDR_W = 2;

   // Status flag bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   // Register offsets on the software port
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_PC_LO = 2'h1;
   localparam logic [1:0] REG_PC_HI = 2'h2;

   // Values after reset, and the program counter step
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] PC_STEP = 16'h0001;

   // Decoded operations
   typedef enum logic [5:0] {
      OP_IDLE, OP_J_UNS_HS, OP_J_UNS_LO, OP_J_NEG, OP_J_POS, OP_J_SGE,
      OP_J_SLT, OP_J_HALF_SET, OP_J_HALF_CLR, OP_J_TF_SET, OP_J_TF_CLR,
      OP_J_OVF_SET, OP_J_OVF_CLR, OP_J_IRQ_ON, OP_J_IRQ_OFF,
      OP_IO_ONE, OP_IO_ZERO, OP_SHL, OP_SHR, OP_SAR, OP_ROT_L, OP_ROT_R,
      OP_NIB_XCHG, OP_FLAG_ONE, OP_FLAG_ZERO, OP_TO_TF, OP_FROM_TF,
      OP_C_ONE, OP_C_ZERO, OP_N_ONE, OP_N_ZERO, OP_Z_ONE, OP_Z_ZERO,
      OP_IRQ_ON
   } fbx_op_t;

   typedef enum logic [2:0] {
      SH_LEFT, SH_RIGHT, SH_ARITH, SH_ROT_L, SH_ROT_R
   } fbx_shift_t;

   typedef enum logic [1:0] {
      ST_READY, ST_JUMP, ST_IO_MOD
   } fbx_state_t;

   typedef struct packed {
      fbx_state_t state;
      logic [15:0] pc;
      logic [15:0] target;
      logic [7:0] status;
      logic [4:0] ioAddr;
      logic [2:0] ioBit;
      logic ioSet;
      logic [7:0] ioWdata;
      logic ioWe;
      logic [4:0] regWaddr;
      logic [7:0] regWdata;
      logic regWe;
      logic [7:0] rdata;
   } fbx_regs_t;

endpackage

// *** core/fbx_shift_if.sv ***
// Purpose: Carrier between the executor and its shift unit
// Assumes: Purely combinational exchange
// Notes: One operand in, result and four flags out
`timescale 1ns/1ns
`default_nettype none
interface fbx_shift_if;
   import fbx_pkg::*;
   fbx_shift_t op;
   logic [7:0] a;
   logic cin;
   logic [7:0] res;
   logic z;
   logic c;
   logic n;
   logic v;
   modport unit (input op, input a, input cin,
                 output res, output z, output c, output n, output v);
   modport user (output op, output a, output cin,
                 input res, input z, input c, input n, input v);
endinterface
`default_nettype wire

// *** core/fbx_shift_unit.sv ***
// Purpose: Shift and rotate datapath with flag results
// Assumes: Operand and carry valid in the issue cycle
// Notes: Overflow is negative xor carry of the result
`timescale 1ns/1ns
`default_nettype none
module fbx_shift_unit
   import fbx_pkg::*;
(
   fbx_shift_if.unit sh
);

   // Result and flags per shift kind
   always_comb
   begin
      sh.res = sh.a;
      sh.c = 1'b0;
      case (sh.op)
         SH_LEFT:
         begin
            sh.res = {sh.a[6:0], 1'b0};
            sh.c = sh.a[7];
         end
         SH_RIGHT:
         begin
            sh.res = {1'b0, sh.a[7:1]};
            sh.c = sh.a[0];
         end
         SH_ARITH:
         begin
            sh.res = {sh.a[7], sh.a[7:1]};
            sh.c = sh.a[0];
         end
         SH_ROT_L:
         begin
            sh.res = {sh.a[6:0], sh.cin};
            sh.c = sh.a[7];
         end
         SH_ROT_R:
         begin
            sh.res = {sh.cin, sh.a[7:1]};
            sh.c = sh.a[0];
         end
         default:
         begin
            sh.res = sh.a;
            sh.c = 1'b0;
         end
      endcase
      sh.z = (sh.res == 8'h00);
      sh.n = sh.res[7];
      sh.v = sh.res[7] ^ sh.c;
   end

endmodule
`default_nettype wire

// *** core/fbx_exec.sv ***
// Purpose: Executes flag branches and the bit and bit-test group
// Assumes: One decoded instruction per issue while instReady is high
// Notes: Holds the program counter and the status flags of the core
`timescale 1ns/1ns
`default_nettype none
module fbx_exec
   import fbx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instValid,
   input wire fbx_op_t instOp,
   input wire logic [6:0] instOffset,
   input wire logic [2:0] instBit,
   input wire logic [4:0] instIoAddr,
   input wire logic [4:0] instRegSel,
   input wire logic [7:0] regRdata,
   input wire logic [7:0] ioRdata,
   input wire logic [1:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic busWr,
   input wire logic busRd,
   output logic instReady,
   output logic [15:0] pcOut,
   output logic [7:0] statusOut,
   output logic [4:0] ioAddr,
   output logic [7:0] ioWdata,
   output logic ioWe,
   output logic [4:0] regWaddr,
   output logic [7:0] regWdata,
   output logic regWe,
   output logic [7:0] busRdata
);

   fbx_regs_t r_q;
   fbx_regs_t r_d;
   fbx_shift_if sh ();

   fbx_shift_unit u_shift (
      .sh(sh)
   );

   // Next state of the whole unit
   always_comb
   begin
      logic take;
      logic isJump;
      logic [15:0] jumpTarget;
      take = 1'b0;
      isJump = 1'b1;
      jumpTarget = r_q.pc + {{9{instOffset[6]}}, instOffset} + PC_STEP;
      r_d = r_q;
      r_d.ioWe = 1'b0;
      r_d.regWe = 1'b0;
      r_d.rdata = 8'h00;
      sh.a = regRdata;
      sh.cin = r_q.status[FLAG_C];
      case (instOp)
         OP_SHR: sh.op = SH_RIGHT;
         OP_SAR: sh.op = SH_ARITH;
         OP_ROT_L: sh.op = SH_ROT_L;
         OP_ROT_R: sh.op = SH_ROT_R;
         default: sh.op = SH_LEFT;
      endcase

      // Software port: read answers next cycle, unmapped reads zero
      if (busRd)
      begin
         case (busAddr)
            REG_STATUS: r_d.rdata = r_q.status;
            REG_PC_LO: r_d.rdata = r_q.pc[7:0];
            REG_PC_HI: r_d.rdata = r_q.pc[15:8];
            default: r_d.rdata = 8'h00;
         endcase
      end
      if (busWr)
      begin
         case (busAddr)
            REG_STATUS: r_d.status = busWdata;
            REG_PC_LO: r_d.pc[7:0] = busWdata;
            REG_PC_HI: r_d.pc[15:8] = busWdata;
            default: r_d.status = r_d.status;
         endcase
      end

      // Branch condition from the status flags
      case (instOp)
         OP_J_UNS_HS: take = ~r_q.status[FLAG_C];
         OP_J_UNS_LO: take = r_q.status[FLAG_C];
         OP_J_NEG: take = r_q.status[FLAG_N];
         OP_J_POS: take = ~r_q.status[FLAG_N];
         OP_J_SGE: take = ~(r_q.status[FLAG_N] ^ r_q.status[FLAG_V]);
         OP_J_SLT: take = r_q.status[FLAG_N] ^ r_q.status[FLAG_V];
         OP_J_HALF_SET: take = r_q.status[FLAG_H];
         OP_J_HALF_CLR: take = ~r_q.status[FLAG_H];
         OP_J_TF_SET: take = r_q.status[FLAG_T];
         OP_J_TF_CLR: take = ~r_q.status[FLAG_T];
         OP_J_OVF_SET: take = r_q.status[FLAG_V];
         OP_J_OVF_CLR: take = ~r_q.status[FLAG_V];
         OP_J_IRQ_ON: take = r_q.status[FLAG_I];
         OP_J_IRQ_OFF: take = ~r_q.status[FLAG_I];
         default:
         begin
            take = 1'b0;
            isJump = 1'b0;
         end
      endcase

      // Sequencer
      case (r_q.state)
         ST_READY:
         begin
            if (instValid && instOp != OP_IDLE)
            begin
               r_d.pc = r_q.pc + PC_STEP;
               r_d.regWaddr = instRegSel;
               if (isJump && take)
               begin
                  // Taken jump spends a second clock; flags untouched
                  r_d.pc = r_q.pc;
                  r_d.target = jumpTarget;
                  r_d.state = ST_JUMP;
               end
               case (instOp)
                  OP_IO_ONE, OP_IO_ZERO:
                  begin
                     r_d.ioAddr = instIoAddr;
                     r_d.ioBit = instBit;
                     r_d.ioSet = (instOp == OP_IO_ONE);
                     r_d.state = ST_IO_MOD;
                  end
                  OP_SHL, OP_SHR, OP_SAR, OP_ROT_L, OP_ROT_R:
                  begin
                     r_d.regWdata = sh.res;
                     r_d.regWe = 1'b1;
                     r_d.status[FLAG_Z] = sh.z;
                     r_d.status[FLAG_C] = sh.c;
                     r_d.status[FLAG_N] = sh.n;
                     r_d.status[FLAG_V] = sh.v;
                  end
                  OP_NIB_XCHG:
                  begin
                     r_d.regWdata = {regRdata[3:0], regRdata[7:4]};
                     r_d.regWe = 1'b1;
                  end
                  OP_FLAG_ONE: r_d.status[instBit] = 1'b1;
                  OP_FLAG_ZERO: r_d.status[instBit] = 1'b0;
                  OP_C_ONE: r_d.status[FLAG_C] = 1'b1;
                  OP_C_ZERO: r_d.status[FLAG_C] = 1'b0;
                  OP_N_ONE: r_d.status[FLAG_N] = 1'b1;
                  OP_N_ZERO: r_d.status[FLAG_N] = 1'b0;
                  OP_Z_ONE: r_d.status[FLAG_Z] = 1'b1;
                  OP_Z_ZERO: r_d.status[FLAG_Z] = 1'b0;
                  OP_IRQ_ON: r_d.status[FLAG_I] = 1'b1;
                  OP_TO_TF: r_d.status[FLAG_T] = regRdata[instBit];
                  OP_FROM_TF:
                  begin
                     r_d.regWdata = regRdata;
                     r_d.regWdata[instBit] = r_q.status[FLAG_T];
                     r_d.regWe = 1'b1;
                  end
                  default: r_d.regWe = 1'b0;
               endcase
            end
         end
         ST_JUMP:
         begin
            // Second clock of a taken jump loads the target
            r_d.pc = r_q.target;
            r_d.state = ST_READY;
         end
         ST_IO_MOD:
         begin
            // Read-modify-write of one I/O bit, other bits kept
            if (r_q.ioSet)
               r_d.ioWdata = ioRdata | (8'h01 << r_q.ioBit);
            else
               r_d.ioWdata = ioRdata & ~(8'h01 << r_q.ioBit);
            r_d.ioWe = 1'b1;
            r_d.state = ST_READY;
         end
         default: r_d.state = ST_READY;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r_q <= '{state: ST_READY, pc: PC_RST, target: PC_RST,
                  status: STATUS_RST, ioAddr: 5'h00, ioBit: 3'h0,
                  ioSet: 1'b0, ioWdata: 8'h00, ioWe: 1'b0,
                  regWaddr: 5'h00, regWdata: 8'h00, regWe: 1'b0,
                  rdata: 8'h00};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // Outputs
   assign instReady = (r_q.state == ST_READY);
   assign pcOut = r_q.pc;
   assign statusOut = r_q.status;
   assign ioAddr = r_q.ioAddr;
   assign ioWdata = r_q.ioWdata;
   assign ioWe = r_q.ioWe;
   assign regWaddr = r_q.regWaddr;
   assign regWdata = r_q.regWdata;
   assign regWe = r_q.regWe;
   assign busRdata = r_q.rdata;

endmodule
`default_nettype wire

// *** verification/fbx_exec_checker.sv ***
// Purpose: Port checks of the flag branch and bit op unit
// Assumes: One clock, reset active low
// Notes: Bound to every fbx_exec instance
`timescale 1ns/1ns
`default_nettype none
module fbx_exec_checker
   import fbx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instValid,
   input wire fbx_op_t instOp,
   input wire logic [6:0] instOffset,
   input wire logic [2:0] instBit,
   input wire logic [7:0] regRdata,
   input wire logic [7:0] ioRdata,
   input wire logic instReady,
   input wire logic [15:0] pcOut,
   input wire logic [7:0] statusOut,
   input wire logic [7:0] ioWdata,
   input wire logic ioWe,
   input wire logic [7:0] regWdata
);
   // Accepted issue
   wire go = instValid && instReady;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // Results one or two clocks after issue
   chk_shl_result: assert property (go && instOp == OP_SHL |=>
      regWdata == {$past(regRdata[6:0]), 1'b0}) else $error("shl data");
   chk_shr_carry: assert property (go && instOp == OP_SHR |=>
      statusOut[FLAG_C] == $past(regRdata[0]) && !regWdata[7])
      else $error("shr carry");
   chk_rotl_carry: assert property (go && instOp == OP_ROT_L |=>
      regWdata[0] == $past(statusOut[FLAG_C])) else $error("rotl carry");
   chk_nibble_swap: assert property (go && instOp == OP_NIB_XCHG |=>
      regWdata == {$past(regRdata[3:0]), $past(regRdata[7:4])})
      else $error("swap data");
   chk_io_one: assert property (go && instOp == OP_IO_ONE |=> !instReady
      ##1 ioWe && ioWdata == ($past(ioRdata) | (8'h01 << $past(instBit, 2))))
      else $error("io set");
   chk_io_zero: assert property (go && instOp == OP_IO_ZERO |=> ##1
      ioWe && ioWdata == ($past(ioRdata) & ~(8'h01 << $past(instBit, 2))))
      else $error("io clear");
   chk_tflag_store: assert property (go && instOp == OP_TO_TF |=>
      statusOut[FLAG_T] == $past(regRdata[instBit])) else $error("bst");
   chk_jump_taken: assert property (go && instOp == OP_J_NEG &&
      statusOut[FLAG_N] |=> !instReady && $stable(pcOut) ##1 pcOut ==
      $past(pcOut, 2) + {{9{$past(instOffset[6], 2)}}, $past(instOffset, 2)}
      + 16'h0001) else $error("jump target");
   chk_jump_skip: assert property (go && instOp == OP_J_POS &&
      statusOut[FLAG_N] |=> instReady && pcOut == $past(pcOut) + 16'h0001)
      else $error("jump skip");
endmodule
bind fbx_exec fbx_exec_checker chk_i (.sys_clk, .resetn, .instValid,
   .instOp, .instOffset, .instBit, .regRdata, .ioRdata, .instReady, .pcOut,
   .statusOut, .ioWdata, .ioWe, .regWdata);
`default_nettype wire

// *** verification/fbx_exec_tb_top.sv ***
// Purpose: Self-checking bench of the flag branch and bit op unit
// Assumes: Flags preset over the software port
// Notes: Expectations follow the flag layout
`timescale 1ns/1ns
`default_nettype none
module fbx_exec_tb_top
   import fbx_pkg::*;
;
   logic sys_clk = 1'b0, resetn = 1'b0, instValid = 1'b0;
   logic busWr = 1'b0, busRd = 1'b0, instReady, ioWe, regWe;
   fbx_op_t instOp = OP_IDLE;
   logic [6:0] instOffset = 7'h00;
   logic [2:0] instBit = 3'h0;
   logic [4:0] instIoAddr = 5'h15, instRegSel = 5'h0D, ioAddr, regWaddr;
   logic [7:0] regRdata = 8'h00, ioRdata = 8'h00, busWdata = 8'h00;
   logic [7:0] statusOut, ioWdata, regWdata, busRdata;
   logic [1:0] busAddr = 2'h0;
   logic [15:0] pcOut;
   int n_fail, n_tests, cyc;

   fbx_exec uut (.sys_clk, .resetn, .instValid, .instOp, .instOffset,
      .instBit, .instIoAddr, .instRegSel, .regRdata, .ioRdata, .busAddr,
      .busWdata, .busWr, .busRd, .instReady, .pcOut, .statusOut, .ioAddr,
      .ioWdata, .ioWe, .regWaddr, .regWdata, .regWe, .busRdata);

   // Clock
   initial
      forever #10 sys_clk = ~sys_clk;

   // Run limit
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   // Compare and verdict
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Software port access, read data checked a cycle later
   task automatic bus(input logic w, input logic [1:0] a,
      input logic [7:0] d);
      @(posedge sys_clk);
      busWr <= w;
      busRd <= !w;
      busAddr <= a;
      busWdata <= d;
      @(posedge sys_clk);
      busWr <= 1'b0;
      busRd <= 1'b0;
      #1;
      if (!w)
         chk("busRdata", d, busRdata);
   endtask

   // One issue cycle
   task automatic iss(input fbx_op_t op, input logic [6:0] k,
      input logic [2:0] b, input logic [7:0] rd);
      @(posedge sys_clk);
      instValid <= 1'b1;
      instOp <= op;
      instOffset <= k;
      instBit <= b;
      regRdata <= rd;
      @(posedge sys_clk);
      instValid <= 1'b0;
      #1;
   endtask

   // One-clock op from preset flags
   task automatic one(input fbx_op_t op, input logic [2:0] b,
      input logic [7:0] rd, p, e, input logic we, input logic [7:0] wd);
      logic [15:0] pc;
      bus(1'b1, REG_STATUS, p);
      pc = pcOut;
      iss(op, 7'h00, b, rd);
      chk("pcOut", pc + PC_STEP, pcOut);
      chk("statusOut", e, statusOut);
      chk("regWe", we, regWe);
      if (we)
      begin
         chk("regWdata", wd, regWdata);
         chk("regWaddr", instRegSel, regWaddr);
      end
   endtask

   // Branch condition of each flag branch op
   function automatic logic taken(input int i, input logic [7:0] s);
      logic [20:0] f;
      logic v;
      f = {FLAG_I, FLAG_V, FLAG_T, FLAG_H, FLAG_V, FLAG_N, FLAG_C};
      v = s[f[3 * ((i - 1) / 2) +: 3]];
      if (i == 5 || i == 6)
         v = s[FLAG_N] ^ s[FLAG_V];
      return v == (i inside {2, 3, 6, 7, 9, 11, 13});
   endfunction

   // Every flag branch under three flag patterns
   task automatic t_branch;
      logic [7:0] s;
      logic [6:0] k;
      logic [15:0] tg;
      logic tk;
      for (int j = 0; j < 3; j++)
         for (int i = 1; i <= 14; i++)
         begin
            s = j == 0 ? 8'h00 : j == 1 ? 8'hFF : 8'h44;
            k = 7'(i * 11 + j * 40);
            tk = taken(i, s);
            bus(1'b1, REG_STATUS, s);
            tg = pcOut + (tk ? {{9{k[6]}}, k} : 16'h0000) + PC_STEP;
            iss(fbx_op_t'(i), k, 3'h0, 8'h00);
            chk("instReady", !tk, instReady);
            if (tk)
            begin
               @(posedge sys_clk);
               #1;
            end
            chk("pcOut", tg, pcOut);
            chk("statusOut", s, statusOut);
         end
   endtask

   // Shifts and rotates with both carry values
   task automatic t_shift;
      logic [7:0] a, r, p, e;
      logic c;
      for (int i = 17; i <= 21; i++)
         for (int j = 0; j < 2; j++)
         begin
            a = j ? 8'h80 : 8'hC3;
            p = j ? 8'h30 : 8'hCF;
            case (i)
               17: {c, r} = {a, 1'b0};
               18: {r, c} = {1'b0, a};
               19: {r, c} = {a[7], a};
               20: {c, r} = {a, p[0]};
               default: {r, c} = {p[0], a};
            endcase
            e = {p[7:4], r[7] ^ c, r[7], r == 8'h00, c};
            one(fbx_op_t'(i), 3'h0, a, p, e, 1'b1, r);
         end
   endtask

   // Nibble swap, T transfers and flag writes
   task automatic t_bits;
      logic [20:0] f;
      logic [7:0] m, p;
      f = {FLAG_I, FLAG_Z, FLAG_Z, FLAG_N, FLAG_N, FLAG_C, FLAG_C};
      one(OP_NIB_XCHG, 3'h0, 8'hA5, 8'h5A, 8'h5A, 1'b1, 8'h5A);
      one(OP_FROM_TF, 3'h7, 8'hFF, 8'hBF, 8'hBF, 1'b1, 8'h7F);
      one(OP_TO_TF, 3'h4, 8'h10, 8'h00, 8'h40, 1'b0, 8'h00);
      for (int b = 0; b < 8; b++)
      begin
         m = 8'h01 << b;
         one(OP_FLAG_ONE, 3'(b), 8'h00, 8'h00, m, 1'b0, 8'h00);
         one(OP_FLAG_ZERO, 3'(b), 8'h00, 8'hFF, ~m, 1'b0, 8'h00);
      end
      for (int i = 27; i <= 33; i++)
      begin
         p = i[0] ? 8'h00 : 8'hFF;
         m = 8'h01 << f[3 * (i - 27) +: 3];
         one(fbx_op_t'(i), 3'h0, 8'h00, p, p ^ m, 1'b0, 8'h00);
      end
   endtask

   // Two-clock I/O bit write
   task automatic t_io(input fbx_op_t op, input logic [2:0] b,
      input logic [7:0] d, e);
      bus(1'b1, REG_STATUS, 8'hA5);
      @(posedge sys_clk);
      ioRdata <= d;
      iss(op, 7'h00, b, 8'h00);
      chk("instReady", 1'b0, instReady);
      chk("ioAddr", instIoAddr, ioAddr);
      @(posedge sys_clk);
      #1;
      chk("ioWe", 1'b1, ioWe);
      chk("ioWdata", e, ioWdata);
      chk("statusOut", 8'hA5, statusOut);
      @(posedge sys_clk);
      #1;
      chk("ioWe", 1'b0, ioWe);
   endtask

   // Reset values, unmapped address and both program counter bytes
   task automatic t_regs;
      bus(1'b0, REG_PC_HI, PC_RST[15:8]);
      bus(1'b0, REG_PC_LO, PC_RST[7:0]);
      bus(1'b1, 2'h3, 8'hFF);
      bus(1'b0, 2'h3, 8'h00);
      bus(1'b0, REG_STATUS, STATUS_RST);
      bus(1'b1, REG_PC_LO, 8'hF0);
      bus(1'b1, REG_PC_HI, 8'h12);
      chk("pcOut", 16'h12F0, pcOut);
      bus(1'b0, REG_PC_LO, 8'hF0);
      bus(1'b0, REG_PC_HI, 8'h12);
   endtask

   // Reset, then scenarios
   initial
   begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      t_regs();
      t_branch();
      t_shift();
      t_bits();
      t_io(OP_IO_ONE, 3'h2, 8'h40, 8'h44);
      t_io(OP_IO_ZERO, 3'h6, 8'hFF, 8'hBF);
      summarize();
   end
endmodule
`default_nettype wire
